// >>> logic/usmc_pkg.sv
// Package for the serial transceiver mode and interrupt-enable block.
// Assumes one 200 MHz system clock and a 32-bit register port.
package usmc_pkg;

   // ******************************
   // Register offsets (byte addresses)
   // ******************************
   localparam logic [7:0] USMC_OFS_CONTROL = 8'h00;
   localparam logic [7:0] USMC_OFS_MODE = 8'h04;
   localparam logic [7:0] USMC_OFS_IRQ_SET = 8'h08;
   localparam logic [7:0] USMC_OFS_IRQ_CLR = 8'h0C;
   localparam logic [7:0] USMC_OFS_IRQ_MASK = 8'h10;
   localparam logic [7:0] USMC_OFS_STATUS = 8'h14;

   // ******************************
   // Control register bits
   // ******************************
   localparam int USMC_CR_RST_ITER = 10;
   localparam int USMC_CR_RTS_ASSERT = 18;
   localparam int USMC_CR_RTS_RELEASE = 19;

   // ******************************
   // Mode register fields
   // ******************************
   localparam int USMC_MR_MODE_LSB = 0;
   localparam int USMC_MR_CLKS_LSB = 4;
   localparam int USMC_MR_CHAR_LENGTH_SEL_LSB = 6;
   localparam int USMC_MR_SYNC = 8;
   localparam int USMC_MR_PAR_LSB = 9;
   localparam int USMC_MR_STOP_LSB = 12;
   localparam int USMC_MR_LOOP_LSB = 14;
   localparam int USMC_MR_BIT_ORDER_SEL = 16;
   localparam int USMC_MR_NINE = 17;
   localparam int USMC_MR_SERIAL_CLOCK_DRIVE_EN = 18;
   localparam int USMC_MR_OVER = 19;
   localparam int USMC_MR_SUPPRESS_NEGATIVE_ACK = 20;
   localparam int USMC_MR_LIMIT_SUCCESSIVE_NEGACK = 21;
   localparam int USMC_MR_ITER_LSB = 24;
   localparam int USMC_MR_FILTER = 28;
   localparam logic [31:0] USMC_MR_WRITABLE = 32'h173F_FFFF;
   localparam logic [31:0] USMC_MR_RESET = 32'h0000_0000;

   // ******************************
   // Interrupt source bits
   // ******************************
   localparam int USMC_IRQ_ITERATION = 10;
   localparam int USMC_IRQ_CHANGE_LSB = 16;
   localparam logic [31:0] USMC_IRQ_VALID = 32'h000F_3FFF;
   localparam int USMC_PIN_IMAGE_LSB = 20;

   // ******************************
   // Timing and codes
   // ******************************
   localparam int USMC_CLK_MHZ = 200;
   localparam int USMC_MCK_DIV = 8;
   localparam logic [3:0] USMC_OVS_16 = 4'hF;
   localparam logic [3:0] USMC_OVS_8 = 4'h7;
   localparam logic [3:0] USMC_LEN_BASE = 4'h5;
   localparam logic [3:0] USMC_LEN_NINE = 4'h9;
   localparam logic RTS_RESET = 1'b0;

   typedef enum logic [3:0] {
      USMC_MODE_NORMAL = 4'h0, USMC_MODE_RS485 = 4'h1, USMC_MODE_HANDSHAKE = 4'h2,
      USMC_MODE_MODEM = 4'h3, USMC_MODE_CARD_T0 = 4'h4, USMC_MODE_CARD_T1 = 4'h6,
      USMC_MODE_INFRARED = 4'h8
   } usmc_mode_e;

   typedef enum logic [1:0] {
      USMC_CLK_MASTER = 2'h0, USMC_CLK_DIV8 = 2'h1, USMC_CLK_EXT = 2'h3
   } usmc_clk_e;

   typedef enum logic [1:0] {
      USMC_LOOP_NORMAL = 2'h0, USMC_LOOP_ECHO = 2'h1, USMC_LOOP_LOCAL = 2'h2, USMC_LOOP_REMOTE = 2'h3
   } usmc_loop_e;

   typedef enum logic [2:0] {
      USMC_PAR_EVEN, USMC_PAR_ODD, USMC_PAR_SPACE, USMC_PAR_MARK, USMC_PAR_NONE, USMC_PAR_MULTIDROP
   } usmc_par_e;

   // Decoded configuration handed to the shifters
   typedef struct packed {
      usmc_mode_e mode;
      logic mode_valid;
      usmc_clk_e clock_source_sel;
      logic clock_valid;
      logic [3:0] char_bits;
      logic sync_mode;
      usmc_par_e check_bit_kind;
      logic [2:0] stop_half_bits;
      logic stop_valid;
      usmc_loop_e channel_loop_sel;
      logic bit_order_sel;
      logic oversample_8x;
      logic suppress_negative_ack;
      logic limit_successive_negack;
      logic [2:0] max_iteration;
      logic rx_filter_en;
   } usmc_cfg_s;

endpackage

// >>> logic/usmc_core.sv
// Mode decode, loopback routing, negative-acknowledge control and interrupt enables
// of a multi-mode serial transceiver. Assumes the shifters, baud generator and
// status sources live outside and that all pins are synchronous to clk_sys.
`timescale 1ns/1ps

// Function
// - Writing one to the release bit drives request-to-send high; zero leaves it.
// - Decode four-bit operating mode; codes other than listed are reserved.
// - Clock source master, master/8 or external; drive serial clock only when enabled, not external.
// - Character length 5 to 8 bits from field; nine-bit override forces 9.
// - Sync bit zero means asynchronous, one means clocked synchronous.
// - Decode parity field: even, odd, space, mark, none, multidrop.
// - Stop bits 1, 1.5 (async only) or 2; code 11 reserved.
// - Echo mode routes receive pin to transmit pin, receiver still fed.
// - Local loopback connects transmitter output to receiver input internally.
// - Remote loopback connects receive pin to transmit pin; code 00 is normal.
// - Local loopback ignores receive pin, holds transmit high; remote disables shifters.
// - Bit order control selects LSB first or MSB first, both directions.
// - Inhibit bit set suppresses every negative acknowledge.
// - Without limiting, send negative acknowledge on every parity error unless inhibited.
// - With limiting, count successive parity errors, stop at limit, raise flag.
// - Repetition limit field gives maximum retransmissions for card protocol T=0.
// - Infrared filter takes two-of-three majority at sample ticks (sixteenth-bit, or eighth-bit with 8x oversampling).
// - Enable-set bits 0 to 13 enable the listed status sources.
// - Enable bits 16 to 19 enable the input-change interrupts; others unused.
// - Write-only clear register disables sources at the same positions.
// - Read-only mask register shows which sources are enabled.
module usmc_core import usmc_pkg::*; #(
   parameter int CHAR_MAX = 9
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic [13:0] src_flags,
   input wire logic [3:0] modem_pins,
   input wire logic sample_tick,
   input wire logic rx_char_done,
   input wire logic rx_parity_err,
   input wire logic [CHAR_MAX-1:0] tx_word,
   input wire logic [CHAR_MAX-1:0] rx_shift_word,
   input wire logic tx_core_bit,
   input wire logic rxd_pin,
   input wire logic sck_in,
   output logic sck_out,
   output logic sck_oe,
   output logic txd_pin,
   output logic rx_core_bit,
   output logic rts_pin,
   output usmc_cfg_s cfg,
   output logic clk_sel_tick,
   output logic bit_tick,
   output logic shifters_enable,
   output logic [CHAR_MAX-1:0] tx_word_ordered,
   output logic [CHAR_MAX-1:0] rx_word_ordered,
   output logic nack_send,
   output logic irq
);

   // Elaboration check: the bit reorder serves characters of up to nine bits in a nine-bit word
   if (CHAR_MAX != 9) begin : g_bad_width
      $error("usmc_core: CHAR_MAX must be 9");
   end

   // ******************************
   // Register state
   // ******************************
   logic [31:0] mode_config;
   logic [31:0] irq_mask;
   logic [3:0] change_flags;
   logic [3:0] pins_last;
   logic iteration_flag;
   logic [2:0] err_count;
   logic [31:0] status_word;
   logic [31:0] next_rdata;
   logic wr_mode;
   logic wr_ctrl;
   logic wr_set;
   logic wr_clr;
   logic rd_status;

   assign wr_ctrl = reg_wr && (reg_addr == USMC_OFS_CONTROL);
   assign wr_mode = reg_wr && (reg_addr == USMC_OFS_MODE);
   assign wr_set = reg_wr && (reg_addr == USMC_OFS_IRQ_SET);
   assign wr_clr = reg_wr && (reg_addr == USMC_OFS_IRQ_CLR);
   assign rd_status = reg_rd && (reg_addr == USMC_OFS_STATUS);

   // Mode register, reserved bits never stored so they read zero
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         mode_config <= USMC_MR_RESET;
      end else if (wr_mode) begin
         mode_config <= reg_wdata & USMC_MR_WRITABLE;
      end
   end

   // Request-to-send pin; release beats assert when both written at once
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rts_pin <= RTS_RESET;
      end else if (wr_ctrl && reg_wdata[USMC_CR_RTS_RELEASE]) begin
         rts_pin <= 1'b1;
      end else if (wr_ctrl && reg_wdata[USMC_CR_RTS_ASSERT]) begin
         rts_pin <= 1'b0;
      end
   end

   // Interrupt mask: set and clear registers share positions, unused bits stay zero
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         irq_mask <= '0;
      end else if (wr_set) begin
         irq_mask <= irq_mask | (reg_wdata & USMC_IRQ_VALID);
      end else if (wr_clr) begin
         irq_mask <= irq_mask & ~(reg_wdata & USMC_IRQ_VALID);
      end
   end

   // ******************************
   // Mode decode
   // ******************************
   logic [3:0] mode_field;
   logic [1:0] char_length_sel_field;
   logic [2:0] par_field;
   logic [1:0] stop_field;

   assign mode_field = mode_config[USMC_MR_MODE_LSB +: 4];
   assign char_length_sel_field = mode_config[USMC_MR_CHAR_LENGTH_SEL_LSB +: 2];
   assign par_field = mode_config[USMC_MR_PAR_LSB +: 3];
   assign stop_field = mode_config[USMC_MR_STOP_LSB +: 2];

   // Reserved mode and stop codes fall back to safe settings, the reserved clock code passes through; each drives its valid bit low
   always_comb begin
      cfg.mode = USMC_MODE_NORMAL;
      cfg.mode_valid = 1'b1;
      case (mode_field)
         4'h0: cfg.mode = USMC_MODE_NORMAL;
         4'h1: cfg.mode = USMC_MODE_RS485;
         4'h2: cfg.mode = USMC_MODE_HANDSHAKE;
         4'h3: cfg.mode = USMC_MODE_MODEM;
         4'h4: cfg.mode = USMC_MODE_CARD_T0;
         4'h6: cfg.mode = USMC_MODE_CARD_T1;
         4'h8: cfg.mode = USMC_MODE_INFRARED;
         default: cfg.mode_valid = 1'b0;
      endcase
      cfg.clock_source_sel = usmc_clk_e'(mode_config[USMC_MR_CLKS_LSB +: 2]);
      cfg.clock_valid = (mode_config[USMC_MR_CLKS_LSB +: 2] != 2'h2);
      if (mode_config[USMC_MR_NINE]) begin
         cfg.char_bits = USMC_LEN_NINE;
      end else begin
         cfg.char_bits = USMC_LEN_BASE + {2'b00, char_length_sel_field};
      end
      cfg.sync_mode = mode_config[USMC_MR_SYNC];
      case (par_field)
         3'b000: cfg.check_bit_kind = USMC_PAR_EVEN;
         3'b001: cfg.check_bit_kind = USMC_PAR_ODD;
         3'b010: cfg.check_bit_kind = USMC_PAR_SPACE;
         3'b011: cfg.check_bit_kind = USMC_PAR_MARK;
         3'b100, 3'b101: cfg.check_bit_kind = USMC_PAR_NONE;
         default: cfg.check_bit_kind = USMC_PAR_MULTIDROP;
      endcase
      // Stop length in half bits; reserved codes fall back to one stop bit
      cfg.stop_valid = 1'b1;
      case (stop_field)
         2'b00: cfg.stop_half_bits = 3'd2;
         2'b01: begin
            cfg.stop_half_bits = mode_config[USMC_MR_SYNC] ? 3'd2 : 3'd3;
            cfg.stop_valid = !mode_config[USMC_MR_SYNC];
         end
         2'b10: cfg.stop_half_bits = 3'd4;
         default: begin
            cfg.stop_half_bits = 3'd2;
            cfg.stop_valid = 1'b0;
         end
      endcase
      cfg.channel_loop_sel = usmc_loop_e'(mode_config[USMC_MR_LOOP_LSB +: 2]);
      cfg.bit_order_sel = mode_config[USMC_MR_BIT_ORDER_SEL];
      cfg.oversample_8x = mode_config[USMC_MR_OVER];
      cfg.suppress_negative_ack = mode_config[USMC_MR_SUPPRESS_NEGATIVE_ACK];
      cfg.limit_successive_negack = mode_config[USMC_MR_LIMIT_SUCCESSIVE_NEGACK];
      cfg.max_iteration = mode_config[USMC_MR_ITER_LSB +: 3];
      cfg.rx_filter_en = mode_config[USMC_MR_FILTER];
   end

   // ******************************
   // Clock source and serial clock output
   // ******************************
   logic [2:0] div_count;
   logic div_tick;
   logic sck_last;
   logic sck_toggle;

   // Master clock divided by eight as a one-cycle enable
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         div_count <= '0;
      end else begin
         div_count <= div_count + 3'd1;
      end
   end
   assign div_tick = (div_count == 3'(USMC_MCK_DIV - 1));

   // External clock pin edge; pin is taken as already synchronous
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         sck_last <= 1'b0;
      end else begin
         sck_last <= sck_in;
      end
   end

   always_comb begin
      case (cfg.clock_source_sel)
         USMC_CLK_MASTER: clk_sel_tick = 1'b1;
         USMC_CLK_DIV8: clk_sel_tick = div_tick;
         USMC_CLK_EXT: clk_sel_tick = sck_in && !sck_last;
         default: clk_sel_tick = 1'b0;
      endcase
   end

   // Serial clock out toggles on the selected rate; never drives in external mode
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         sck_toggle <= 1'b0;
         sck_oe <= 1'b0;
      end else begin
         if (clk_sel_tick) begin
            sck_toggle <= !sck_toggle;
         end
         sck_oe <= mode_config[USMC_MR_SERIAL_CLOCK_DRIVE_EN] && (cfg.clock_source_sel != USMC_CLK_EXT);
      end
   end
   assign sck_out = sck_toggle;

   // ******************************
   // Oversampling and receive filter
   // ******************************
   logic [3:0] ovs_count;
   logic [2:0] rx_hist;
   logic rx_filtered;

   // Bit tick every 16 or 8 sample ticks
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ovs_count <= '0;
      end else if (sample_tick) begin
         if (ovs_count >= (cfg.oversample_8x ? USMC_OVS_8 : USMC_OVS_16)) begin
            ovs_count <= '0;
         end else begin
            ovs_count <= ovs_count + 4'd1;
         end
      end
   end
   assign bit_tick = sample_tick && (ovs_count >= (cfg.oversample_8x ? USMC_OVS_8 : USMC_OVS_16));

   // Three-sample history taken on each sample tick (a sixteenth or an eighth of a bit); idle line is high
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rx_hist <= 3'b111;
      end else if (sample_tick) begin
         rx_hist <= {rx_hist[1:0], rxd_pin};
      end
   end

   // Majority of three rejects single-sample glitches at the cost of latency
   assign rx_filtered = cfg.rx_filter_en ?
      ((rx_hist[0] & rx_hist[1]) | (rx_hist[1] & rx_hist[2]) | (rx_hist[0] & rx_hist[2])) : rxd_pin;

   // ******************************
   // Channel loop routing
   // ******************************
   // Registered pin paths: one clk_sys of delay is far below any bit time
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         txd_pin <= 1'b1;
         rx_core_bit <= 1'b1;
      end else begin
         case (cfg.channel_loop_sel)
            USMC_LOOP_ECHO: begin
               txd_pin <= rxd_pin;
               rx_core_bit <= rx_filtered;
            end
            USMC_LOOP_LOCAL: begin
               txd_pin <= 1'b1;
               rx_core_bit <= tx_core_bit;
            end
            USMC_LOOP_REMOTE: begin
               txd_pin <= rxd_pin;
               rx_core_bit <= 1'b1;
            end
            default: begin
               txd_pin <= tx_core_bit;
               rx_core_bit <= rx_filtered;
            end
         endcase
      end
   end

   // Shifters idle in remote loopback
   assign shifters_enable = (cfg.channel_loop_sel != USMC_LOOP_REMOTE);

   // ******************************
   // Bit order
   // ******************************
   // Reverse only the live character bits so MSB-first shifts out of bit 0
   function automatic logic [CHAR_MAX-1:0] usmc_order(input logic [CHAR_MAX-1:0] w,
                                                        input logic [3:0] len, input logic msb);
      logic [CHAR_MAX-1:0] r;
      r = '0;
      for (int i = 0; i < CHAR_MAX; i++) begin
         if (4'(i) < len) begin
            r[i] = msb ? w[len - 4'(i) - 4'd1] : w[i];
         end
      end
      return r;
   endfunction

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         tx_word_ordered <= '0;
         rx_word_ordered <= '0;
      end else begin
         tx_word_ordered <= usmc_order(tx_word, cfg.char_bits, cfg.bit_order_sel);
         rx_word_ordered <= usmc_order(rx_shift_word, cfg.char_bits, cfg.bit_order_sel);
      end
   end

   // ******************************
   // Negative acknowledge
   // ******************************
   logic limit_hit;
   logic rst_iter;

   assign limit_hit = (err_count >= cfg.max_iteration);
   assign rst_iter = wr_ctrl && reg_wdata[USMC_CR_RST_ITER];

   // Successive parity errors count up; a clean character restarts the run
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         err_count <= '0;
         nack_send <= 1'b0;
      end else begin
         nack_send <= 1'b0;
         if (rx_char_done && !rx_parity_err) begin
            err_count <= '0;
         end else if (rx_char_done && rx_parity_err) begin
            if (!cfg.limit_successive_negack) begin
               nack_send <= !cfg.suppress_negative_ack;
            end else if (!limit_hit) begin
               err_count <= err_count + 3'd1;
               nack_send <= !cfg.suppress_negative_ack;
            end
         end
      end
   end

   // Limit flag sticky; a new hit wins over a simultaneous reset command
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         iteration_flag <= 1'b0;
      end else if (rx_char_done && rx_parity_err && cfg.limit_successive_negack && limit_hit) begin
         iteration_flag <= 1'b1;
      end else if (rst_iter) begin
         iteration_flag <= 1'b0;
      end
   end

   // ******************************
   // Modem input changes and status
   // ******************************
   // One generate per pin: change sets the flag, status read clears it, set wins
   for (genvar g = 0; g < 4; g++) begin : g_change
      always_ff @(posedge clk_sys) begin
         if (sys_rst) begin
            change_flags[g] <= 1'b0;
         end else if (modem_pins[g] != pins_last[g]) begin
            change_flags[g] <= 1'b1;
         end else if (rd_status) begin
            change_flags[g] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         pins_last <= '0;
      end else begin
         pins_last <= modem_pins;
      end
   end

   always_comb begin
      status_word = '0;
      status_word[13:0] = src_flags;
      status_word[USMC_IRQ_ITERATION] = iteration_flag;
      status_word[USMC_IRQ_CHANGE_LSB +: 4] = change_flags;
      status_word[USMC_PIN_IMAGE_LSB +: 4] = modem_pins;
   end

   // Any enabled source raises the line; pin images carry no mask bit
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status_word & irq_mask & USMC_IRQ_VALID);
      end
   end

   // ******************************
   // Read port
   // ******************************
   // Write-only and unmapped offsets read zero
   always_comb begin
      next_rdata = '0;
      case (reg_addr)
         USMC_OFS_MODE: next_rdata = mode_config;
         USMC_OFS_IRQ_MASK: next_rdata = irq_mask;
         USMC_OFS_STATUS: next_rdata = status_word;
         default: next_rdata = '0;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
      end else begin
         reg_rdata <= '0;
      end
   end

endmodule

// >>> tb/usmc_core_props.sv
// Port-level assertions and covers for usmc_core.
// Assumes one clock domain; bound into every usmc_core instance.
`timescale 1ns/1ps
module usmc_core_props import usmc_pkg::*; #(
   parameter int CHAR_MAX = 9
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic rx_char_done,
   input wire logic rx_parity_err,
   input wire logic [CHAR_MAX-1:0] tx_word,
   input wire logic tx_core_bit,
   input wire logic rxd_pin,
   input wire logic sck_oe,
   input wire logic txd_pin,
   input wire logic rx_core_bit,
   input wire logic rts_pin,
   input wire usmc_cfg_s cfg,
   input wire logic shifters_enable,
   input wire logic [CHAR_MAX-1:0] tx_word_ordered,
   input wire logic nack_send,
   input wire logic irq
);
   // ****
   // Assertions
   // ****
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   logic ctl_wr;
   // Control writes decoded once for the request-to-send checks
   assign ctl_wr = reg_wr && reg_addr == USMC_OFS_CONTROL;
   rts_release_a: assert property (ctl_wr && reg_wdata[19] |=> rts_pin)
      else $error("rts not released");
   rts_keep_a: assert property (ctl_wr && !reg_wdata[19] && !reg_wdata[18] |=> rts_pin == $past(rts_pin))
      else $error("rts moved");
   sck_ext_a: assert property (cfg.clock_source_sel == USMC_CLK_EXT |=> !sck_oe)
      else $error("sck driven on ext");
   echo_path_a: assert property (cfg.channel_loop_sel == USMC_LOOP_ECHO |=> txd_pin == $past(rxd_pin))
      else $error("echo path wrong");
   local_loop_a: assert property (cfg.channel_loop_sel == USMC_LOOP_LOCAL |=> txd_pin && rx_core_bit == $past(tx_core_bit))
      else $error("local loop wrong");
   remote_loop_a: assert property (cfg.channel_loop_sel == USMC_LOOP_REMOTE |-> !shifters_enable ##1 txd_pin == $past(rxd_pin))
      else $error("remote loop wrong");
   order_lsb_a: assert property (!cfg.bit_order_sel |=>
      tx_word_ordered == ($past(tx_word) & ~({CHAR_MAX{1'b1}} << $past(cfg.char_bits))))
      else $error("lsb order wrong");
   nack_err_a: assert property (rx_char_done && rx_parity_err && !cfg.limit_successive_negack && !cfg.suppress_negative_ack |=> nack_send)
      else $error("nack missing");
   nack_inhibit_a: assert property (rx_char_done && cfg.suppress_negative_ack |=> !nack_send)
      else $error("nack not inhibited");
   nack_cause_a: assert property (nack_send |-> $past(rx_char_done) && $past(rx_parity_err) && !$past(cfg.suppress_negative_ack))
      else $error("nack without cause");
   // Main scenarios reached
   cover property (nack_send);
   cover property (irq);
   cover property (cfg.channel_loop_sel == USMC_LOOP_REMOTE);
endmodule
bind usmc_core usmc_core_props #(.CHAR_MAX(CHAR_MAX)) usmc_core_props_inst (.*);

// >>> tb/usmc_peer_model.sv
// Serial peer: drives the receive line and the modem inputs.
// Assumes the bench pulses ring_go for one ring-indicator change.
`timescale 1ns/1ps
module usmc_peer_model (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic ring_go,
   output logic rxd_pin,
   output logic [3:0] modem_pins
);
   // ****
   // Line side
   // ****
   logic [7:0] pattern;
   // Rotating pattern, so a stale copy of the line seldom matches by luck
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         pattern <= 8'hCA;
         modem_pins <= 4'h0;
      end else begin
         pattern <= {pattern[6:0], pattern[7]};
         modem_pins[0] <= modem_pins[0] ^ ring_go;
      end
   end
   assign rxd_pin = pattern[7];
endmodule

// >>> tb/usmc_core_tb_top.sv
// Self-checking bench for usmc_core: registers, mode decode, loops, NACK, irq.
// Assumes the peer model drives the line side and the checker is bound.
`timescale 1ns/1ps
module usmc_core_tb_top import usmc_pkg::*;;
   logic clk_sys, sys_rst, reg_wr, reg_rd, sample_tick, rx_char_done, rx_parity_err, ring_go;
   logic tx_core_bit, rxd_pin, sck_in, sck_out, sck_oe, txd_pin, rx_core_bit, rts_pin;
   logic clk_sel_tick, bit_tick, shifters_enable, nack_send, irq;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, d;
   logic [13:0] src_flags;
   logic [3:0] modem_pins;
   logic [8:0] tx_word, rx_shift_word, tx_word_ordered, rx_word_ordered, cnt;
   usmc_cfg_s cfg;
   int err_count = 0;
   int n_tests = 0;
   usmc_core usmc_core_inst (.*);
   usmc_peer_model usmc_peer_model_inst (.*);
   // ****
   // Clock, shifter-side stimulus, bus tasks
   // ****
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   // Shifter side keeps moving so the loop paths see real traffic
   always @(posedge clk_sys) begin
      cnt <= sys_rst ? 9'h000 : cnt + 9'h001;
      tx_core_bit <= cnt[0] ^ cnt[3];
      sample_tick <= cnt[1:0] == 2'h0;
      sck_in <= cnt[2];
      tx_word <= cnt;
      rx_shift_word <= ~cnt;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic pulse(input logic e, input logic exp);
      @(posedge clk_sys);
      rx_char_done <= 1'b1;
      rx_parity_err <= e;
      @(posedge clk_sys);
      rx_char_done <= 1'b0;
      #1 chk(nack_send, exp);
   endtask
   task automatic wait_irq(input logic exp);
      repeat (3) @(posedge clk_sys);
      #1 chk(irq, exp);
   endtask
   task automatic end_of_test;
      if (err_count == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // ****
   // Scenarios
   // ****
   task automatic t_reset;
      rd(USMC_OFS_IRQ_MASK);
      chk(d, 32'h0000_0000);
      rd(USMC_OFS_IRQ_SET);
      chk(d, 32'h0000_0000);
      rd(8'h40);
      chk(d, 32'h0000_0000);
      wr(USMC_OFS_CONTROL, 32'h0008_0000);
      #1 chk(rts_pin, 32'h0000_0001);
      wr(USMC_OFS_CONTROL, 32'h0000_0000);
      #1 chk(rts_pin, 32'h0000_0001);
   endtask
   task automatic t_mode;
      logic [3:0] i;
      logic [31:0] m;
      logic mv, cv, sv;
      usmc_cfg_s g, ex;
      for (int k = 0; k < 16; k++) begin
         i = 4'(k);
         m = {3'h0, i[0], 1'b0, i[2:0], 2'h0, i[2], i[1], i[3], i[0], i[2], i[0], i[1:0], i[1:0], i[2:0], i[3],
            i[1:0], i[1:0], i};
         mv = i inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8};
         cv = i[1:0] != 2'h2;
         sv = i[1:0] != 2'h3 && !(i[1:0] == 2'h1 && i[3]);
         ex = usmc_cfg_s'({mv ? i : 4'h0, mv, cv ? i[1:0] : 2'h0, cv, i[2] ? 4'h9 : 4'h5 + {2'h0, i[1:0]}, i[3],
            i[2] ? {2'h2, i[1]} : i[2:0], sv ? 3'h2 + {1'b0, i[1:0]} : 3'h2, sv, i[1:0], i[0], i[3], i[1], i[2],
            i[2:0], i[0]});
         // Reserved bits written high must read back low
         wr(USMC_OFS_MODE, m | 32'hE8C0_0000);
         #1 g = cfg;
         if (!cv) begin
            g.clock_source_sel = USMC_CLK_MASTER;
         end
         chk(32'(g), 32'(ex));
         rd(USMC_OFS_MODE);
         chk(d, m);
      end
   endtask
   task automatic t_loop;
      logic r, t;
      logic [1:0] ex;
      for (int c = 0; c < 4; c++) begin
         wr(USMC_OFS_MODE, 32'(c) << USMC_MR_LOOP_LSB);
         repeat (6) begin
            @(negedge clk_sys);
            r = rxd_pin;
            t = tx_core_bit;
            @(negedge clk_sys);
            ex = c == 0 ? {t, r} : c == 1 ? {r, r} : c == 2 ? {1'b1, t} : {r, 1'b1};
            chk({txd_pin, rx_core_bit, shifters_enable}, {ex, c != 3});
         end
      end
   endtask
   task automatic t_nack;
      wr(USMC_OFS_MODE, 32'h0000_0004);
      pulse(1'b1, 1'b1);
      pulse(1'b0, 1'b0);
      wr(USMC_OFS_MODE, 32'h0010_0004);
      pulse(1'b1, 1'b0);
      wr(USMC_OFS_MODE, 32'h0220_0004);
      pulse(1'b1, 1'b1);
      pulse(1'b1, 1'b1);
      pulse(1'b1, 1'b0);
      rd(USMC_OFS_STATUS);
      chk(d & 32'h0000_0400, 32'h0000_0400);
      wr(USMC_OFS_CONTROL, 32'h0000_0400);
      rd(USMC_OFS_STATUS);
      chk(d & 32'h0000_0400, 32'h0000_0000);
      pulse(1'b0, 1'b0);
      pulse(1'b1, 1'b1);
   endtask
   task automatic t_irq;
      wr(USMC_OFS_IRQ_SET, 32'hFFFF_FFFF);
      rd(USMC_OFS_IRQ_MASK);
      chk(d, 32'h000F_3FFF);
      wr(USMC_OFS_IRQ_CLR, 32'h0000_0001);
      rd(USMC_OFS_IRQ_MASK);
      chk(d, 32'h000F_3FFE);
      @(posedge clk_sys);
      src_flags <= 14'h0002;
      wait_irq(1'b1);
      wr(USMC_OFS_IRQ_CLR, 32'hFFFF_FFFF);
      wait_irq(1'b0);
      wr(USMC_OFS_IRQ_SET, 32'h0001_0000);
      src_flags <= 14'h0000;
      ring_go <= 1'b1;
      @(posedge clk_sys);
      ring_go <= 1'b0;
      wait_irq(1'b1);
      rd(USMC_OFS_STATUS);
      chk(d & 32'h0011_0000, 32'h0011_0000);
      wait_irq(1'b0);
   endtask
   initial begin
      {reg_wr, reg_rd, rx_char_done, rx_parity_err, ring_go} = 5'h00;
      {reg_addr, reg_wdata, src_flags} = 54'h0;
      sys_rst = 1'b1;
      repeat (8) @(posedge clk_sys);
      sys_rst <= 1'b0;
      t_reset;
      t_mode;
      t_loop;
      t_nack;
      t_irq;
      end_of_test;
   end
   // Run needs well under a thousand cycles
   initial begin
      #20000;
      err_count++;
      end_of_test;
   end
endmodule
